// >>> hw/svrf_pkg.sv
// Shared widths, encodings and carrier structs of the vector register file.
// Assumes one core clock domain and an issue stage that sends ops in program order.
package svrf_pkg;

   localparam int VGRAN_BITS = 128;
   localparam int VMAX_BITS  = 2048;
   localparam int VQUADS     = 2;
   localparam int VLEN       = VGRAN_BITS * VQUADS;
   localparam int PW         = VLEN / 8;
   localparam int NUM_VREG   = 32;
   localparam int NUM_PREG   = 16;
   localparam int NUM_GOV_LO = 8;
   localparam int LEG_BITS   = 128;
   localparam int LEG_BYTES  = LEG_BITS / 8;
   localparam int VIDX_W     = $clog2(NUM_VREG);
   localparam int PIDX_W     = $clog2(NUM_PREG);
   localparam int LANE_W     = $clog2(PW);
   localparam int QV_W       = $clog2(VQUADS + 1);

   typedef enum logic [2:0] {ES_B, ES_H, ES_S, ES_D, ES_Q} svrf_esize_t;

   typedef enum logic [1:0] {VK_FULL, VK_LEGACY, VK_SCALAR} svrf_vkind_t;

   typedef enum logic [2:0] {
      FO_NONE,
      FAULT_MASK_SET_ALL_OP,
      FAULT_MASK_WRITE_OP,
      FO_LOAD_FAULT,
      FAULT_MASK_READ_OP,
      FAULT_MASK_READ_FLAGS_OP
   } svrf_ffr_op_t;

   typedef struct packed {
      logic                 valid;
      svrf_vkind_t          kind;
      logic [VIDX_W-1:0]    idx;
      svrf_esize_t          esize;
      logic                 predicated;
      logic                 zeroing;
      logic                 gov_low_only;
      logic [PIDX_W-1:0]    gov_idx;
      logic [VLEN-1:0]      data;
   } svrf_vwr_t;

   typedef struct packed {
      logic                 valid;
      logic [PIDX_W-1:0]    idx;
      svrf_esize_t          esize;
      logic                 predicated;
      logic                 zeroing;
      logic                 gov_low_only;
      logic [PIDX_W-1:0]    gov_idx;
      logic                 permute;
      logic [PW-1:0]        data;
   } svrf_pwr_t;

   typedef struct packed {
      svrf_ffr_op_t         op;
      svrf_esize_t          esize;
      logic [LANE_W-1:0]    fault_lane;
      logic [PW-1:0]        data;
   } svrf_ffr_cmd_t;

   typedef struct packed {
      logic                 v_valid;
      logic [VIDX_W-1:0]    v_idx;
      logic                 p_valid;
      logic [PIDX_W-1:0]    p_idx;
   } svrf_rd_req_t;

   typedef struct packed {
      logic                 v_valid;
      logic [VLEN-1:0]      v_data;
      logic                 p_valid;
      logic [PW-1:0]        p_data;
      logic                 f_valid;
      logic                 f_flags;
      logic [PW-1:0]        f_data;
      logic                 gov_err;
   } svrf_rd_resp_t;

   typedef struct packed {
      logic [NUM_VREG-1:0][VLEN-1:0] vreg;
      logic [NUM_PREG-1:0][PW-1:0]   preg;
      logic [PW-1:0]                 first_fault_mask_reg;
      svrf_rd_resp_t                 resp;
   } svrf_state_t;

endpackage

// >>> hw/svrf_lane_expand.sv
// Spreads a mask over lanes of the given size, one bit per vector byte.
// Assumes mask bit b pairs with vector byte b; purely combinational.
`timescale 1ns/1ps
module svrf_lane_expand (
   input  wire logic [svrf_pkg::PW-1:0] gov,
   input  svrf_pkg::svrf_esize_t        esize,
   output wire logic [svrf_pkg::PW-1:0] active,
   output wire logic [svrf_pkg::PW-1:0] canon
);

   for (genvar b = 0; b < svrf_pkg::PW; b++) begin : g_bit
      // [RL14] Lane-size interpretation.
      // [RL8] Lowest bit decides truth.
      assign active[b] = (esize == svrf_pkg::ES_H) ? gov[(b / 2) * 2] :
                         (esize == svrf_pkg::ES_S) ? gov[(b / 4) * 4] :
                         (esize == svrf_pkg::ES_D) ? gov[(b / 8) * 8] :
                         (esize == svrf_pkg::ES_Q) ? gov[(b / 16) * 16] : gov[b];
      // [RL9] Canonical element bits.
      assign canon[b]  = (esize == svrf_pkg::ES_H) ? (b % 2 == 0) :
                         (esize == svrf_pkg::ES_S) ? (b % 4 == 0) :
                         (esize == svrf_pkg::ES_D) ? (b % 8 == 0) :
                         (esize == svrf_pkg::ES_Q) ? (b % 16 == 0) : 1'b1;
   end

endmodule

// >>> hw/svrf_core.sv
// Wide vector, lane mask and first-fault mask storage with masked write logic.
// Assumes the issue stage drives at most one op of each kind per cycle,
// in program order, from the same core clock.
`timescale 1ns/1ps

// Function
// [RL1] Thirty-two wide vector registers, width a multiple of 128, at most 2048.
// [RL2] Vector lanes may be 8, 16, 32, 64 or 128 bits, chosen per op.
// [RL3] Where lane order matters, lanes are handled lowest number first.
// [RL4] Low 128 bits of each wide register are the legacy register storage.
// [RL5] Legacy writes clear accessible upper bits when vector length exceeds 128.
// [RL6] Sixteen mask registers, one bit per vector byte.
// [RL7] Mask elements of 1, 2, 4, 8 or 16 bits pair with same-numbered lanes.
// [RL8] A mask element is true exactly when its lowest bit is one.
// [RL9] Upper element bits ignored on read and written zero, except permutes.
// [RL10] Some ops accept only mask registers 0 to 7 as governing mask.
// [RL11] True governing element makes the lane active, false makes it inactive.
// [RL12] Zeroing mode writes zero to inactive destination elements.
// [RL13] Merging mode keeps inactive destination elements unchanged.
// [RL14] One mask reads differently per lane size, element k at bit k times E.
// [RL15] First-fault mask has the same layout as the ordinary masks.
// [RL16] Set-all op makes every first-fault mask element true.
// [RL17] A failed lane clears its fault mask element and every higher one.
// [RL18] Vector loads never turn a fault mask element from false to true.
// [RL19] Only read ops read the fault mask; only write, set-all and load faults write it.
// [RL20] Fault mask accesses take effect in program order without barriers.
// [RL21] Narrow scalar results clear the upper destination bits.
// [RL22] Ops without governing mask treat every lane as active.
// [RL23] Vector width is a design constant; mask widths are one eighth.
module svrf_core (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  svrf_pkg::svrf_vwr_t          vec_wr,
   input  svrf_pkg::svrf_pwr_t          mask_wr,
   input  svrf_pkg::svrf_ffr_cmd_t      ffr_cmd,
   input  svrf_pkg::svrf_rd_req_t       rd_req,
   input  wire logic [svrf_pkg::QV_W-1:0] cur_vl_quads,
   output svrf_pkg::svrf_rd_resp_t      rd_resp
);

   // [RL23] Package-derived widths.
   svrf_pkg::svrf_state_t           s_reg;
   svrf_pkg::svrf_state_t           s_next;
   logic [svrf_pkg::PW-1:0]         vgov;
   logic [svrf_pkg::PW-1:0]         pgov;
   logic [svrf_pkg::PW-1:0]         vact;
   logic [svrf_pkg::PW-1:0]         pact;
   logic [svrf_pkg::PW-1:0]         pcanon;
   logic [svrf_pkg::PW-1:0]         pdata;
   logic [svrf_pkg::VLEN-1:0]       vnew;
   logic [svrf_pkg::PW-1:0]         pnew;
   logic [svrf_pkg::PW-1:0]         fnew;
   logic                            vgov_bad;
   logic                            pgov_bad;
   int                              scalar_bytes;
   int                              fault_base;

   // [RL10] Restricted governing set.
   assign vgov_bad = vec_wr.predicated && vec_wr.gov_low_only &&
                     (int'(vec_wr.gov_idx) >= svrf_pkg::NUM_GOV_LO);
   assign pgov_bad = mask_wr.predicated && mask_wr.gov_low_only &&
                     (int'(mask_wr.gov_idx) >= svrf_pkg::NUM_GOV_LO);

   // [RL22] Unmasked ops all active.
   assign vgov = vec_wr.predicated ? s_reg.preg[vec_wr.gov_idx] : {svrf_pkg::PW{1'b1}};
   assign pgov = mask_wr.predicated ? s_reg.preg[mask_wr.gov_idx] : {svrf_pkg::PW{1'b1}};

   // [RL7] Vector-side lane pairing.
   svrf_lane_expand u_vexp (
      .gov    (vgov),
      .esize  (vec_wr.esize),
      .active (vact),
      .canon  ()
   );

   svrf_lane_expand u_pexp (
      .gov    (pgov),
      .esize  (mask_wr.esize),
      .active (pact),
      .canon  (pcanon)
   );

   // New contents of the addressed wide vector register.
   always_comb begin
      vnew         = s_reg.vreg[vec_wr.idx];
      scalar_bytes = 1 << int'(vec_wr.esize);
      // [RL2] Lane size per op.
      for (int b = 0; b < svrf_pkg::PW; b++) begin
         case (vec_wr.kind)
            svrf_pkg::VK_LEGACY: begin
               // [RL4] Shared low half.
               if (b < svrf_pkg::LEG_BYTES) begin
                  vnew[8*b +: 8] = vec_wr.data[8*b +: 8];
               end
            end
            svrf_pkg::VK_SCALAR: begin
               // [RL21] Scalar zero extension.
               vnew[8*b +: 8] = (b < scalar_bytes) ? vec_wr.data[8*b +: 8] : 8'h00;
            end
            default: begin
               // [RL11] Active lanes written.
               if (vact[b]) begin
                  vnew[8*b +: 8] = vec_wr.data[8*b +: 8];
               // [RL12] Zeroing inactive lanes.
               end else if (vec_wr.zeroing) begin
                  vnew[8*b +: 8] = 8'h00;
               end
               // [RL13] Merging keeps old bytes.
            end
         endcase
      end
      // [RL5] Clear accessible upper bits.
      // Quads beyond the current length are left alone; they are not accessible.
      if (vec_wr.kind == svrf_pkg::VK_LEGACY) begin
         for (int q = 1; q < svrf_pkg::VQUADS; q++) begin
            if (q < int'(cur_vl_quads)) begin
               vnew[q*svrf_pkg::VGRAN_BITS +: svrf_pkg::VGRAN_BITS] = '0;
            end
         end
      end
   end

   // New contents of the addressed mask register.
   always_comb begin
      pnew  = s_reg.preg[mask_wr.idx];
      // [RL9] Canonical form unless permuting.
      pdata = mask_wr.permute ? mask_wr.data : (mask_wr.data & pcanon);
      for (int b = 0; b < svrf_pkg::PW; b++) begin
         // [RL11] Active mask elements written.
         if (pact[b]) begin
            pnew[b] = pdata[b];
         // [RL12] Zeroing inactive elements.
         end else if (mask_wr.zeroing) begin
            pnew[b] = 1'b0;
         end
      end
   end

   // New contents of the first-fault mask.
   always_comb begin
      fnew       = s_reg.first_fault_mask_reg;
      fault_base = int'(ffr_cmd.fault_lane) << int'(ffr_cmd.esize);
      case (ffr_cmd.op)
         // [RL16] Set all elements true.
         svrf_pkg::FAULT_MASK_SET_ALL_OP: begin
            fnew = {svrf_pkg::PW{1'b1}};
         end
         // [RL19] Only direct writer.
         svrf_pkg::FAULT_MASK_WRITE_OP: begin
            fnew = ffr_cmd.data;
         end
         svrf_pkg::FO_LOAD_FAULT: begin
            // [RL17] Clear failed lane upward.
            // [RL18] Loads only clear bits.
            // [RL3] Ascending lane order.
            for (int b = 0; b < svrf_pkg::PW; b++) begin
               if (b >= fault_base) begin
                  fnew[b] = 1'b0;
               end
            end
         end
         default: begin
            fnew = s_reg.first_fault_mask_reg;
         end
      endcase
   end

   // Whole next state; read answers are one-cycle pulses.
   always_comb begin
      s_next                 = s_reg;
      s_next.resp.v_valid    = 1'b0;
      s_next.resp.p_valid    = 1'b0;
      s_next.resp.f_valid    = 1'b0;
      s_next.resp.f_flags    = 1'b0;
      s_next.resp.gov_err    = 1'b0;
      // [RL1] Register array write.
      if (vec_wr.valid && !vgov_bad) begin
         s_next.vreg[vec_wr.idx] = vnew;
      end
      // [RL6] Mask register write.
      if (mask_wr.valid && !pgov_bad) begin
         s_next.preg[mask_wr.idx] = pnew;
      end
      // [RL20] One ordered op per cycle.
      // [RL15] Same layout as masks.
      s_next.first_fault_mask_reg = fnew;
      // [RL10] Refused op reported.
      s_next.resp.gov_err = (vec_wr.valid && vgov_bad) || (mask_wr.valid && pgov_bad);
      // Reads return the value before any write of the same cycle.
      if (rd_req.v_valid) begin
         s_next.resp.v_valid = 1'b1;
         s_next.resp.v_data  = s_reg.vreg[rd_req.v_idx];
      end
      if (rd_req.p_valid) begin
         s_next.resp.p_valid = 1'b1;
         s_next.resp.p_data  = s_reg.preg[rd_req.p_idx];
      end
      // [RL19] Only read ops read it.
      if (ffr_cmd.op == svrf_pkg::FAULT_MASK_READ_OP ||
          ffr_cmd.op == svrf_pkg::FAULT_MASK_READ_FLAGS_OP) begin
         s_next.resp.f_valid = 1'b1;
         s_next.resp.f_flags = (ffr_cmd.op == svrf_pkg::FAULT_MASK_READ_FLAGS_OP);
         s_next.resp.f_data  = s_reg.first_fault_mask_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rd_resp = s_reg.resp;

   // Checks kept beside the logic they guard.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_set_all;
      ffr_cmd.op == svrf_pkg::FAULT_MASK_SET_ALL_OP;
   endsequence

   sequence s_fault_byte1;
      ffr_cmd.op == svrf_pkg::FO_LOAD_FAULT && ffr_cmd.esize == svrf_pkg::ES_B &&
      ffr_cmd.fault_lane == svrf_pkg::LANE_W'(1);
   endsequence

   sequence s_ffr_read;
      ffr_cmd.op == svrf_pkg::FAULT_MASK_READ_OP;
   endsequence

   a_ffr_set_all: // [RL16]
      assert property (s_set_all |=> s_reg.first_fault_mask_reg == {svrf_pkg::PW{1'b1}})
      else $error("Fault mask not all true after set-all.");

   a_ffr_true_false: // [RL17]
      assert property (s_set_all ##1 s_fault_byte1 |=>
                       s_reg.first_fault_mask_reg == {{(svrf_pkg::PW-1){1'b0}}, 1'b1})
      else $error("Fault at lane one did not leave only lane zero true.");

   a_ffr_no_rise: // [RL18]
      assert property (ffr_cmd.op == svrf_pkg::FO_LOAD_FAULT |=>
                       (s_reg.first_fault_mask_reg & ~$past(s_reg.first_fault_mask_reg)) == '0)
      else $error("Load fault turned a fault mask bit true.");

   a_ffr_read_order: // [RL20]
      assert property (s_ffr_read |=> rd_resp.f_valid && !rd_resp.f_flags &&
                       rd_resp.f_data == $past(s_reg.first_fault_mask_reg))
      else $error("Fault mask read returned wrong or late data.");

   a_legacy_view: // [RL5]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_LEGACY && !vgov_bad &&
                       int'(cur_vl_quads) == svrf_pkg::VQUADS |=>
                       s_reg.vreg[$past(vec_wr.idx)] ==
                       {{(svrf_pkg::VLEN-svrf_pkg::LEG_BITS){1'b0}},
                        $past(vec_wr.data[svrf_pkg::LEG_BITS-1:0])})
      else $error("Legacy write did not keep low bits and clear upper bits.");

   a_zero_inactive: // [RL12]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_FULL && !vgov_bad &&
                       vec_wr.predicated && vec_wr.zeroing && vgov == '0 |=>
                       s_reg.vreg[$past(vec_wr.idx)] == '0)
      else $error("Zeroing write with no active lane left nonzero data.");

   a_merge_inactive: // [RL13]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_FULL && !vgov_bad &&
                       vec_wr.predicated && !vec_wr.zeroing && vgov == '0 |=>
                       s_reg.vreg[$past(vec_wr.idx)] == $past(s_reg.vreg[vec_wr.idx]))
      else $error("Merging write with no active lane changed the register.");

   a_gov_low_only: // [RL10]
      assert property (vec_wr.valid && vgov_bad |=> rd_resp.gov_err &&
                       s_reg.vreg[$past(vec_wr.idx)] == $past(s_reg.vreg[vec_wr.idx]))
      else $error("Restricted governing mask was not refused.");

   a_scalar_zext: // [RL21]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_SCALAR && !vgov_bad &&
                       vec_wr.esize == svrf_pkg::ES_S |=>
                       s_reg.vreg[$past(vec_wr.idx)][svrf_pkg::VLEN-1:32] == '0)
      else $error("Scalar result left upper bits nonzero.");

   a_mask_canon: // [RL9]
      assert property (mask_wr.valid && !mask_wr.permute && !mask_wr.predicated &&
                       mask_wr.esize == svrf_pkg::ES_H |=>
                       (s_reg.preg[$past(mask_wr.idx)] & {(svrf_pkg::PW/2){2'b10}}) == '0)
      else $error("Mask write left upper element bits set.");

   a_vread_data: // [RL4]
      assert property (rd_req.v_valid |=> rd_resp.v_valid &&
                       rd_resp.v_data == $past(s_reg.vreg[rd_req.v_idx]))
      else $error("Vector read returned wrong or late data.");

   a_unmasked_all: // [RL22]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_FULL && !vec_wr.predicated |=>
                       s_reg.vreg[$past(vec_wr.idx)] == $past(vec_wr.data))
      else $error("Unmasked write missed a byte.");

   a_active_lane: // [RL14]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_FULL && !vgov_bad &&
                       vec_wr.esize == svrf_pkg::ES_D && vgov[0] |=>
                       s_reg.vreg[$past(vec_wr.idx)][63:0] == $past(vec_wr.data[63:0]))
      else $error("Active lane zero was not written.");

   a_low_bit_rules: // [RL8]
      assert property (vec_wr.valid && vec_wr.kind == svrf_pkg::VK_FULL && !vgov_bad &&
                       vec_wr.esize == svrf_pkg::ES_H && !vec_wr.zeroing &&
                       vgov[1:0] == 2'h2 |=>
                       s_reg.vreg[$past(vec_wr.idx)][15:0] == $past(s_reg.vreg[vec_wr.idx][15:0]))
      else $error("Element with low bit clear was written.");

   sequence s_ffr_quiet;
      ffr_cmd.op inside {svrf_pkg::FO_NONE, svrf_pkg::FAULT_MASK_READ_OP,
                         svrf_pkg::FAULT_MASK_READ_FLAGS_OP};
   endsequence

   sequence s_ffr_fault;
      ffr_cmd.op == svrf_pkg::FO_LOAD_FAULT;
   endsequence

   a_ffr_read_only: // [RL19]
      assert property (s_ffr_quiet |=> $stable(s_reg.first_fault_mask_reg))
      else $error("Fault mask changed without a writer.");

   a_ffr_write: // [RL19]
      assert property (ffr_cmd.op == svrf_pkg::FAULT_MASK_WRITE_OP |=>
                       s_reg.first_fault_mask_reg == $past(ffr_cmd.data))
      else $error("Fault mask write did not store its data.");

   a_ffr_prefix: // [RL17]
      assert property (s_set_all ##1 s_ffr_fault |=>
                       ((s_reg.first_fault_mask_reg + svrf_pkg::PW'(1)) & s_reg.first_fault_mask_reg) == '0)
      else $error("Fault mask is not true elements then false ones.");

   a_gov_err_cause: // [RL10]
      assert property (!(vec_wr.valid && vgov_bad) && !(mask_wr.valid && pgov_bad) |=>
                       !rd_resp.gov_err)
      else $error("Allowed governing mask was reported refused.");

   a_mask_zeroing: // [RL12]
      assert property (mask_wr.valid && !pgov_bad && mask_wr.zeroing && pgov == '0 |=>
                       s_reg.preg[$past(mask_wr.idx)] == '0)
      else $error("Zeroing mask write left bits set.");

endmodule

// >>> testbench/svrf_issue_model.sv
// Issue-stage stand-in that drives requests into the vector register file core.
// Assumes the bench calls send or idle once per cycle, from one process, in program order.
`timescale 1ns/1ps
module svrf_issue_model (
   input  wire logic              ref_clk,
   output svrf_pkg::svrf_vwr_t     vec_wr,
   output svrf_pkg::svrf_pwr_t     mask_wr,
   output svrf_pkg::svrf_ffr_cmd_t ffr_cmd,
   output svrf_pkg::svrf_rd_req_t  rd_req
);
   initial begin
      vec_wr  = '0;
      mask_wr = '0;
      ffr_cmd = '0;
      rd_req  = '0;
   end

   // One op per edge in program order.
   task automatic send(input svrf_pkg::svrf_vwr_t v, input svrf_pkg::svrf_pwr_t p,
                       input svrf_pkg::svrf_ffr_cmd_t f, input svrf_pkg::svrf_rd_req_t r);
      @(negedge ref_clk);
      vec_wr  = v;
      mask_wr = p;
      ffr_cmd = f;
      rd_req  = r;
   endtask

   // Data fields and the vector read index are inverted so a stale value never looks like a fresh one.
   task automatic idle();
      @(negedge ref_clk);
      vec_wr.valid   = 1'b0;
      vec_wr.data    = ~vec_wr.data;
      mask_wr.valid  = 1'b0;
      mask_wr.data   = ~mask_wr.data;
      ffr_cmd.op     = svrf_pkg::FO_NONE;
      ffr_cmd.data   = ~ffr_cmd.data;
      rd_req.v_valid = 1'b0;
      rd_req.p_valid = 1'b0;
      rd_req.v_idx   = ~rd_req.v_idx;
   endtask
endmodule

// >>> testbench/scalable_vector_register_file_tb.sv
// Self-checking bench for the vector register file core with a shadow model.
// Assumes requests come from the issue model on falling edges, results one cycle later.
`timescale 1ns/1ps
module scalable_vector_register_file_tb;
   localparam int VL = svrf_pkg::VLEN;
   localparam int PW = svrf_pkg::PW;
   typedef struct packed {
      logic [1:0]  kind;
      logic [VL:0] data;
   } svrf_exp_t;

   logic                      ref_clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic [svrf_pkg::QV_W-1:0] cur_vl_quads = 2'h2;
   svrf_pkg::svrf_vwr_t       vec_wr;
   svrf_pkg::svrf_pwr_t       mask_wr;
   svrf_pkg::svrf_ffr_cmd_t   ffr_cmd;
   svrf_pkg::svrf_rd_req_t    rd_req;
   svrf_pkg::svrf_rd_resp_t   rd_resp;
   logic [VL-1:0]             vr [32];
   logic [PW-1:0]             pr [16];
   logic [PW-1:0]             first_fault_mask_reg;
   svrf_exp_t                 exp_q [$];
   int                        miscompares = 0;
   int                        num_checks = 0;
   logic [31:0]               rng = 32'h15;

   always #2 ref_clk = ~ref_clk;

   svrf_issue_model u_issue (.ref_clk(ref_clk), .vec_wr(vec_wr), .mask_wr(mask_wr),
                             .ffr_cmd(ffr_cmd), .rd_req(rd_req));
   svrf_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .vec_wr(vec_wr), .mask_wr(mask_wr),
                  .ffr_cmd(ffr_cmd), .rd_req(rd_req), .cur_vl_quads(cur_vl_quads),
                  .rd_resp(rd_resp));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [VL-1:0] rnd_vec();
      for (int i = 0; i < VL / 32; i++) rnd_vec[i*32+:32] = xs();
   endfunction

   // Element k of E bits governs bytes k*E up to k*E+E-1.
   function automatic logic [PW-1:0] act(input logic [PW-1:0] g, input svrf_pkg::svrf_esize_t es);
      int e;
      e = 1 << int'(es);
      for (int b = 0; b < PW; b++) act[b] = g[(b / e) * e];
   endfunction

   task automatic finish_test();
      $display("Checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input svrf_exp_t got);
      svrf_exp_t e;
      num_checks++;
      if (exp_q.size() == 0) begin
         miscompares++;
         $display("ERROR %0t unexpected result of kind %0d", $time, got.kind);
      end else begin
         e = exp_q.pop_front();
         if (got !== e) begin
            miscompares++;
            $display("ERROR %0t kind %0d got %h expected %h", $time, e.kind, got.data, e.data);
         end
      end
   endtask

   always @(posedge ref_clk) begin
      #1;
      if (rd_resp.v_valid === 1'b1) check({2'h0, 1'b0, rd_resp.v_data});
      if (rd_resp.p_valid === 1'b1) check({2'h1, {(VL+1-PW){1'b0}}, rd_resp.p_data});
      if (rd_resp.f_valid === 1'b1)
         check({2'h2, {(VL-PW){1'b0}}, rd_resp.f_flags, rd_resp.f_data});
      if (rd_resp.gov_err === 1'b1) check({2'h3, {(VL+1){1'b0}}});
   end

   task automatic op(input svrf_pkg::svrf_vwr_t v, input svrf_pkg::svrf_pwr_t p,
                     input svrf_pkg::svrf_ffr_cmd_t f, input svrf_pkg::svrf_rd_req_t r,
                     input logic [svrf_pkg::QV_W-1:0] q);
      logic [PW-1:0] opr [16];
      logic [PW-1:0] a;
      logic          bad_v;
      logic          bad_p;
      opr = pr;
      bad_v = v.valid & v.predicated & v.gov_low_only & (v.gov_idx >= 8);
      bad_p = p.valid & p.predicated & p.gov_low_only & (p.gov_idx >= 8);
      if (r.v_valid) exp_q.push_back({2'h0, 1'b0, vr[r.v_idx]});
      if (r.p_valid) exp_q.push_back({2'h1, {(VL+1-PW){1'b0}}, pr[r.p_idx]});
      if (f.op inside {svrf_pkg::FAULT_MASK_READ_OP, svrf_pkg::FAULT_MASK_READ_FLAGS_OP})
         exp_q.push_back({2'h2, {(VL-PW){1'b0}}, f.op == svrf_pkg::FAULT_MASK_READ_FLAGS_OP, first_fault_mask_reg});
      if (bad_v | bad_p) exp_q.push_back({2'h3, {(VL+1){1'b0}}});
      // Active lanes take data, inactive zero or keep.
      if (v.valid & !bad_v) begin
         a = v.predicated ? act(opr[v.gov_idx], v.esize) : '1;
         for (int b = 0; b < PW; b++) begin
            case (v.kind)
               svrf_pkg::VK_FULL: begin
                  if (a[b]) vr[v.idx][b*8+:8] = v.data[b*8+:8];
                  else if (v.zeroing) vr[v.idx][b*8+:8] = 8'h00;
               end
               // Legacy write clears accessible upper quads.
               svrf_pkg::VK_LEGACY: begin
                  if (b < 16) vr[v.idx][b*8+:8] = v.data[b*8+:8];
                  else if (b / 16 < int'(q)) vr[v.idx][b*8+:8] = 8'h00;
               end
               default: vr[v.idx][b*8+:8] = (b < (1 << int'(v.esize))) ? v.data[b*8+:8] : 8'h00;
            endcase
         end
      end
      if (p.valid & !bad_p) begin
         a = p.predicated ? act(opr[p.gov_idx], p.esize) : '1;
         for (int b = 0; b < PW; b++) begin
            if (a[b]) pr[p.idx][b] = p.data[b] & (p.permute | (b % (1 << int'(p.esize)) == 0));
            else if (p.zeroing) pr[p.idx][b] = 1'b0;
         end
      end
      // Set-all, raw write, load faults only clear.
      case (f.op)
         svrf_pkg::FAULT_MASK_SET_ALL_OP: first_fault_mask_reg = '1;
         svrf_pkg::FAULT_MASK_WRITE_OP: first_fault_mask_reg = f.data;
         svrf_pkg::FO_LOAD_FAULT: begin
            for (int b = 0; b < PW; b++)
               if (b >= (int'(f.fault_lane) << int'(f.esize))) first_fault_mask_reg[b] = 1'b0;
         end
         default: ;
      endcase
      u_issue.send(v, p, f, r);
      cur_vl_quads = q;
   endtask

   task automatic ffr_only(input svrf_pkg::svrf_ffr_op_t o, input logic [4:0] lane);
      svrf_pkg::svrf_ffr_cmd_t f;
      f = '0;
      f.op = o;
      f.fault_lane = lane;
      op('0, '0, f, '0, 2'h2);
   endtask

   task automatic burst(input int n);
      svrf_pkg::svrf_vwr_t     v;
      svrf_pkg::svrf_pwr_t     p;
      svrf_pkg::svrf_ffr_cmd_t f;
      svrf_pkg::svrf_rd_req_t  r;
      logic [31:0]             t;
      logic [31:0]             u;
      for (int i = 0; i < n; i++) begin
         t = xs();
         u = xs();
         v.valid        = t[0];
         v.kind         = svrf_pkg::svrf_vkind_t'(t[2:1] % 3);
         v.idx          = {3'h0, t[4:3]};
         v.esize        = svrf_pkg::svrf_esize_t'(t[7:5] % 5);
         v.predicated   = t[8];
         v.zeroing      = t[9];
         v.gov_low_only = t[10];
         v.gov_idx      = t[14:11];
         v.data         = rnd_vec();
         p.valid        = t[15];
         p.idx          = t[19:16];
         p.esize        = svrf_pkg::svrf_esize_t'(t[22:20] % 5);
         p.predicated   = t[23];
         p.zeroing      = t[24];
         p.gov_low_only = t[25];
         p.gov_idx      = t[29:26];
         p.permute      = t[30];
         p.data         = v.data[2*PW-1:PW];
         f.op           = svrf_pkg::svrf_ffr_op_t'(u[2:0] % 6);
         f.esize        = svrf_pkg::svrf_esize_t'(u[5:3] % 5);
         f.fault_lane   = u[10:6];
         f.data         = v.data[PW-1:0];
         r.v_valid      = u[11];
         r.v_idx        = {3'h0, u[13:12]};
         r.p_valid      = u[14];
         r.p_idx        = u[18:15];
         op(v, p, f, r, u[19] ? 2'h2 : 2'h1);
      end
   endtask

   task automatic drain();
      u_issue.idle();
      for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(posedge ref_clk);
      @(negedge ref_clk);
      if (exp_q.size() != 0) begin
         miscompares++;
         $display("ERROR %0t %0d results never came", $time, exp_q.size());
         finish_test();
      end
   endtask

   task automatic do_reset();
      @(negedge ref_clk);
      rst_n = 1'b0;
      for (int i = 0; i < 32; i++) vr[i] = '0;
      for (int i = 0; i < 16; i++) pr[i] = '0;
      first_fault_mask_reg = '0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
   endtask

   initial begin
      do_reset();
      ffr_only(svrf_pkg::FAULT_MASK_READ_OP, 5'h0);
      ffr_only(svrf_pkg::FAULT_MASK_SET_ALL_OP, 5'h0);
      ffr_only(svrf_pkg::FO_LOAD_FAULT, 5'h1);
      ffr_only(svrf_pkg::FAULT_MASK_READ_FLAGS_OP, 5'h0);
      ffr_only(svrf_pkg::FAULT_MASK_WRITE_OP, 5'h0);
      ffr_only(svrf_pkg::FO_LOAD_FAULT, 5'h0);
      ffr_only(svrf_pkg::FAULT_MASK_READ_OP, 5'h0);
      burst(3000);
      drain();
      do_reset();
      burst(600);
      drain();
      finish_test();
   end
endmodule
